/* File: bench/sdt_front_model.sv */
// comparator front end, following the level the bench commands
`timescale 1ns/100ps
`default_nettype none
module sdt_front_model (
   // clock and command
   input wire logic clk_in,
   input wire logic level_in,
   input wire logic slow_in,
   // comparator
   output logic comp_out
);
   logic lag_r;
   always_ff @(posedge clk_in) begin
      lag_r <= level_in;
   end
   // slow mode: a settling lag of one cycle
   // current dac taken as powered before precharge, so the level is valid at once
   assign comp_out = slow_in ? lag_r : level_in;
endmodule // sdt_front_model
`default_nettype wire

/* File: bench/sdt_touch_monitor.sv */
// port checker for the touch counter
`timescale 1ns/100ps
`default_nettype none
module sdt_touch_monitor (
   // clock, reset, bus
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   // pins and events
   input wire logic sense_pin_gnd_out,
   input wire logic sense_pin_bus_out,
   input wire logic block_event_out,
   input wire logic delay_event_out,
   input wire logic interval_tc_out
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);
   logic tc_seen_r;
   // -------------------------------------------------
   // only an accepted write can re-arm the timer
   // -------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (rst_in || (avs_write_in && !avs_waitrequest_out)) begin
         tc_seen_r <= 1'b0;
      end else if (interval_tc_out) begin
         tc_seen_r <= 1'b1;
      end
   end
   sequence new_req;
      $rose(avs_read_in) || $rose(avs_write_in);
   endsequence
   sequence one_wait;
      avs_waitrequest_out ##1 !avs_waitrequest_out;
   endsequence
   wait_ack_a: assert property (new_req |-> one_wait) else $error("no single wait cycle");
   idle_ready_a: assert property (!avs_read_in && !avs_write_in |-> !avs_waitrequest_out)
      else $error("wait while idle");
   rdata_hold_a: assert property (!avs_read_in |=> $stable(avs_readdata_out))
      else $error("read data moved");
   tc_single_a: assert property (interval_tc_out |=> !interval_tc_out)
      else $error("long terminal pulse");
   tc_once_a: assert property (interval_tc_out |-> !tc_seen_r)
      else $error("timer ran twice");
   pins_excl_a: assert property (!(sense_pin_gnd_out && sense_pin_bus_out))
      else $error("both phases on");
   delay_sticky_a: assert property (delay_event_out && !avs_write_in |=> delay_event_out)
      else $error("delay event lost");
   event_sticky_a: assert property (block_event_out && !avs_write_in |=> block_event_out)
      else $error("block event lost");
endmodule // sdt_touch_monitor
bind sdt_touch_counter sdt_touch_monitor u_mon (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out), .sense_pin_gnd_out(sense_pin_gnd_out),
   .sense_pin_bus_out(sense_pin_bus_out), .block_event_out(block_event_out),
   .delay_event_out(delay_event_out), .interval_tc_out(interval_tc_out));
`default_nettype wire

/* File: bench/tb_sdt_touch_counter.sv */
// self-checking bench for the touch counter
`timescale 1ns/100ps
`default_nettype none
module tb_sdt_touch_counter;
   logic ref_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [3:0] addr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] be = 4'hf;
   logic [31:0] rdata;
   logic wait_w, cmp, gnd, bus_ph, seqb, bev, dev, tc;
   logic level = 1'b0;
   logic slow = 1'b0;
   logic [1:0] cmode = 2'h0;
   logic [31:0] rng_r = 32'h219a286f;
   logic [69:0] hist_r = '0;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   logic [31:0] exp_cnt = 32'h0;
   logic [5:0] tload = 6'h0;
   logic sd_on = 1'b0;
   logic tc_done = 1'b0;
   logic prev_s = 1'b0;
   int miscompares = 0;
   int check_count = 0;
   int tog = 0;
   int gap = 0;
   int min_gap = 0;
   int pin_err = 0;
   int e, i, k, n;
   sdt_touch_counter dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wait_w), .comparator_0_out_in(cmp),
      .sense_pin_gnd_out(gnd), .sense_pin_bus_out(bus_ph), .seq_bit_out(seqb),
      .block_event_out(bev), .delay_event_out(dev), .interval_tc_out(tc));
   sdt_front_model u_front (.clk_in(ref_clk_in), .level_in(level), .slow_in(slow), .comp_out(cmp));
   initial begin
      forever #2.5 ref_clk_in = ~ref_clk_in;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic check(input string what, input logic [31:0] ex, input logic [31:0] seen);
      check_count++;
      if (seen !== ex) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, ex, seen);
      end
   endtask
   // -------------------------------------------------
   // bus master: waitrequest is looked at just before each edge
   // -------------------------------------------------
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
      logic ws;
      int c;
      c = 0;
      addr <= a;
      wdata <= d;
      be <= b;
      rd <= ~w;
      wr <= w;
      do begin
         @(negedge ref_clk_in);
         ws = wait_w;
         @(posedge ref_clk_in);
         c++;
      end while (ws !== 1'b0 && c < 50);
      if (c == 50) check("bus answer", 32'h0, 32'h1);
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge ref_clk_in);
   endtask
   task automatic rdr(input logic [3:0] a, input logic [31:0] ex, input logic [31:0] m);
      exp_q.push_back(ex & m);
      msk_q.push_back(m);
      bus(1'b0, a, 32'h0, 4'hf);
   endtask
   task automatic wrr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hf);
   endtask
   always @(negedge ref_clk_in) begin
      if (rd && wait_w === 1'b0 && exp_q.size() > 0) check("read data", exp_q.pop_front(), rdata & msk_q.pop_front());
   end
   // -------------------------------------------------
   // stimulus and reference: count synced comparator highs in the start window
   // -------------------------------------------------
   always @(posedge ref_clk_in) begin
      rng_r <= xs(rng_r);
      level <= (cmode == 2'h2) ? rng_r[0] : cmode[0];
      hist_r <= {hist_r[68:0], cmp};
      prev_s <= seqb;
      gap <= (seqb !== prev_s) ? 1 : gap + 1;
      if (seqb !== prev_s) begin
         tog <= tog + 1;
         if (gap > 0 && gap < min_gap) min_gap <= gap;
      end
      if (gnd !== prev_s || bus_ph !== ~prev_s) pin_err <= pin_err + 1;
      if (tc === 1'b1) begin
         e = 0;
         for (k = 2; k <= tload + 2; k++) e += hist_r[k];
         exp_cnt <= sd_on ? 32'(e) : 32'h0;
         tc_done <= 1'b1;
      end
   end
   task automatic meas(input logic [7:0] c, input logic [5:0] t);
      wrr(sdt_pkg::ADDR_CTRL, 32'h0);
      wrr(sdt_pkg::ADDR_TIMER, {26'h0, t});
      tload <= t;
      sd_on <= c[sdt_pkg::CTRL_SDMODE_BIT];
      tc_done <= 1'b0;
      wrr(sdt_pkg::ADDR_CTRL, {24'h0, c});
      for (n = 0; n < 300 && tc_done !== 1'b1; n++) @(posedge ref_clk_in);
      repeat (6) @(posedge ref_clk_in);
      check("interval end", 32'h1, {31'h0, tc_done});
      rdr(sdt_pkg::ADDR_COUNT, exp_cnt, 32'hffff);
      rdr(sdt_pkg::ADDR_CNT_LO, exp_cnt, 32'hff);
      rdr(sdt_pkg::ADDR_CNT_HI, exp_cnt >> 8, 32'hff);
      rdr(sdt_pkg::ADDR_STAT, 32'h3, 32'h3);
      $display("measure ctrl %h load %0d done", c, t);
   endtask
   task automatic give_verdict;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge ref_clk_in);
      miscompares++;
      give_verdict();
   end
   initial begin : main
      logic [3:0] ra[8];
      logic [31:0] rv[8];
      ra = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h9};
      rv = '{32'h0, 32'h0, 32'h3f, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
      repeat (5) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      @(posedge ref_clk_in);
      for (i = 0; i < 8; i++) rdr(ra[i], rv[i], 32'hffff);
      bus(1'b1, sdt_pkg::ADDR_TIMER, 32'h15, 4'he);
      wrr(4'h9, 32'hff);
      rdr(sdt_pkg::ADDR_TIMER, 32'h3f, 32'h3f);
      rdr(4'h9, 32'h0, 32'hffffffff);
      $display("register test done");
      cmode <= 2'h1;
      meas(8'h09, 6'd10);
      meas(8'h01, 6'd10);
      cmode <= 2'h0;
      meas(8'h09, 6'd20);
      cmode <= 2'h2;
      slow <= 1'b1;
      meas(8'h09, rng_r[5:0] | 6'h4);
      @(negedge ref_clk_in);
      check("capture event", 32'h1, {31'h0, bev});
      @(posedge ref_clk_in);
      cmode <= 2'h1;
      meas(8'h49, 6'd63);
      wrr(sdt_pkg::ADDR_CTRL, 32'h0);
      rdr(sdt_pkg::ADDR_COUNT, 32'h0, 32'hffff);
      wrr(sdt_pkg::ADDR_DELAY, 32'h4);
      wrr(sdt_pkg::ADDR_CTRL, 32'h11);
      for (n = 0; n < 300 && dev !== 1'b1; n++) @(posedge ref_clk_in);
      check("delay event", 32'h1, {31'h0, dev});
      rdr(sdt_pkg::ADDR_STAT, 32'h4, 32'h4);
      wrr(sdt_pkg::ADDR_CTRL, 32'h0);
      @(negedge ref_clk_in);
      check("delay clear", 32'h0, {31'h0, dev});
      @(posedge ref_clk_in);
      // positive integration, one-shot: counts every clock until the comparator trips
      cmode <= 2'h0;
      slow <= 1'b0;
      wrr(sdt_pkg::ADDR_CTRL, 32'h0);
      wrr(sdt_pkg::ADDR_CTRL, 32'h83);
      repeat (20) @(posedge ref_clk_in);
      cmode <= 2'h1;
      repeat (30) @(posedge ref_clk_in);
      rdr(sdt_pkg::ADDR_COUNT, 32'd25, 32'hffff);
      rdr(sdt_pkg::ADDR_STAT, 32'h97, 32'h97);
      wrr(sdt_pkg::ADDR_CTRL, 32'h0);
      $display("event test done");
      for (i = 0; i < 2; i++) begin
         wrr(sdt_pkg::ADDR_SEQ, 32'(i * 8'h13));
         rdr(sdt_pkg::ADDR_SEQ, 32'(i * 8'h13), 32'h1f);
         wrr(sdt_pkg::ADDR_CTRL, 32'h31);
         @(negedge ref_clk_in);
         tog = 0;
         pin_err = 0;
         gap = -100000;
         min_gap = 100000;
         repeat (800) @(posedge ref_clk_in);
         check("sequence toggles", 32'h1, {31'h0, tog > 1});
         check("prescale gap", 32'h1, {31'h0, min_gap >= (i ? 8 : 1)});
         check("sense pins", 32'h0, 32'(pin_err));
         wrr(sdt_pkg::ADDR_CTRL, 32'h0);
      end
      $display("sequencer test done");
      give_verdict();
   end
endmodule // tb_sdt_touch_counter
`default_nettype wire

/* File: core/sdt_touch_counter.sv */
// sigma-delta touch counter: control, sequencer, interval timer and avalon slave
`timescale 1ns/100ps
`default_nettype none
module sdt_touch_counter (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // avalon-mm slave
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // analog front end
   input wire logic comparator_0_out_in,
   output logic sense_pin_gnd_out,
   output logic sense_pin_bus_out,
   output logic seq_bit_out,
   // events
   output logic block_event_out,
   output logic delay_event_out,
   output logic interval_tc_out
);
   // ------------------------------------------------
   // registers
   // ------------------------------------------------
   logic [7:0] ctrl_r;
   logic [4:0] seq_r;
   logic [5:0] timer_load_r;
   logic [5:0] delay_load_r;
   logic ack_r;
   logic [31:0] rdata_r;
   logic cmp_meta_r;
   logic cmp_sync_r;
   logic cmp_prev_r;
   logic en_d_r;
   logic [7:0] div_r;
   logic [11:0] lfsr_r;
   logic seq_tick;
   logic [5:0] timer_r;
   logic timer_run_r;
   logic start_r;
   logic tc_r;
   logic [5:0] delay_r;
   logic delay_run_r;
   logic delay_ev_r;
   logic [7:0] cnt_lo_r;
   logic [7:0] cnt_hi_r;
   logic frozen_r;
   logic capture_ev_r;
   logic ovf_ev_r;
   sdt_pkg::sdt_state_t state_r;
   logic enabled;
   logic sd_on;
   logic count_en;
   logic lo_wrap;
   logic trip;
   logic wr_ctrl;

   assign enabled = ctrl_r[sdt_pkg::CTRL_EN_BIT];
   assign sd_on = enabled & ctrl_r[sdt_pkg::CTRL_SDMODE_BIT];
   assign wr_ctrl = avs_write_in & ack_r & (avs_address_in == sdt_pkg::ADDR_CTRL)
      & avs_byteenable_in[0];
   // ------------------------------------------------
   // avalon slave: one wait cycle then acknowledge
   // ------------------------------------------------
   assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_r;
   assign avs_readdata_out = rdata_r;

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read_in | avs_write_in) & ~ack_r;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         ctrl_r <= sdt_pkg::CTRL_RST;
         seq_r <= sdt_pkg::SEQ_RST;
         timer_load_r <= sdt_pkg::TIMER_RST;
         delay_load_r <= sdt_pkg::DELAY_RST;
      end else if (avs_write_in & ack_r & avs_byteenable_in[0]) begin
         case (avs_address_in)
            sdt_pkg::ADDR_CTRL: ctrl_r <= avs_writedata_in[7:0];
            sdt_pkg::ADDR_SEQ: seq_r <= avs_writedata_in[4:0];
            sdt_pkg::ADDR_TIMER: timer_load_r <= avs_writedata_in[5:0];
            sdt_pkg::ADDR_DELAY: delay_load_r <= avs_writedata_in[5:0];
            default: ;
         endcase
      end
   end

   // read data loaded in the wait cycle, then held until the next read
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         rdata_r <= 32'h0000_0000;
      end else if (avs_read_in & ~ack_r) begin
         case (avs_address_in)
            sdt_pkg::ADDR_CTRL: rdata_r <= {24'h00_0000, ctrl_r};
            sdt_pkg::ADDR_SEQ: rdata_r <= {27'h000_0000, seq_r};
            sdt_pkg::ADDR_TIMER: rdata_r <= {26'h000_0000, timer_load_r};
            sdt_pkg::ADDR_DELAY: rdata_r <= {26'h000_0000, delay_load_r};
            sdt_pkg::ADDR_CNT_LO: rdata_r <= {24'h00_0000, cnt_lo_r};
            sdt_pkg::ADDR_CNT_HI: rdata_r <= {24'h00_0000, cnt_hi_r};
            sdt_pkg::ADDR_STAT: rdata_r <= {18'h0, timer_r, frozen_r,
               delay_ev_r, ovf_ev_r, capture_ev_r, start_r, cmp_sync_r, state_r};
            sdt_pkg::ADDR_COUNT: rdata_r <= {16'h0000, cnt_hi_r, cnt_lo_r};
            default: rdata_r <= 32'h0000_0000;
         endcase
      end
   end
   // ------------------------------------------------
   // comparator synchroniser
   // ------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         cmp_meta_r <= 1'b0;
         cmp_sync_r <= 1'b0;
         cmp_prev_r <= 1'b0;
      end else begin
         cmp_meta_r <= comparator_0_out_in;
         cmp_sync_r <= cmp_meta_r;
         cmp_prev_r <= cmp_sync_r;
      end
   end
   assign trip = cmp_sync_r & ~cmp_prev_r;
   // ------------------------------------------------
   // prescaler and pseudo-random sequencer
   // ------------------------------------------------
   // free-running so the sequence phase is not tied to measurement start
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         div_r <= sdt_pkg::DIV_RST;
      end else begin
         div_r <= div_r + 8'h01;
      end
   end
   // tick when the low div bits are all ones: divide by 2**div, div capped at DIV_MAX
   always_comb begin
      logic [3:0] dsel;
      dsel = seq_r[sdt_pkg::SEQ_DIV_MSB:sdt_pkg::SEQ_DIV_LSB];
      if (dsel > sdt_pkg::DIV_MAX) begin
         dsel = sdt_pkg::DIV_MAX;
      end
      seq_tick = ((div_r | ~((8'h01 << dsel) - 8'h01)) == 8'hff)
         || (dsel == 4'h0);
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         lfsr_r <= sdt_pkg::LFSR_SEED;
      end else if (seq_tick) begin
         if (seq_r[sdt_pkg::SEQ_LONG_BIT]) begin
            lfsr_r <= {lfsr_r[10:0], lfsr_r[11] ^ lfsr_r[10] ^ lfsr_r[9] ^ lfsr_r[3]};
         end else begin
            lfsr_r <= {4'h0, lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
         end
      end
   end
   // ------------------------------------------------
   // sense pin phases
   // ------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         seq_bit_out <= 1'b0;
         sense_pin_gnd_out <= 1'b0;
         sense_pin_bus_out <= 1'b0;
      end else begin
         seq_bit_out <= seq_r[sdt_pkg::SEQ_LONG_BIT] ? lfsr_r[11] : lfsr_r[7];
         if (enabled & ctrl_r[sdt_pkg::CTRL_SENSE_EN_BIT]) begin
            // break-before-make is left to the pad; phases never overlap here
            sense_pin_bus_out <= ctrl_r[sdt_pkg::CTRL_PRSCLK_BIT] ? ~seq_bit_out
               : div_r[0];
            sense_pin_gnd_out <= ctrl_r[sdt_pkg::CTRL_PRSCLK_BIT] ? seq_bit_out
               : ~div_r[0];
         end else begin
            sense_pin_bus_out <= 1'b0;
            sense_pin_gnd_out <= 1'b0;
         end
      end
   end
   // ------------------------------------------------
   // interval timer and delay counter
   // ------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         en_d_r <= 1'b0;
      end else begin
         en_d_r <= enabled;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in || !enabled) begin
         timer_r <= 6'h00;
         timer_run_r <= 1'b0;
         start_r <= 1'b0;
         tc_r <= 1'b0;
      end else if (!en_d_r) begin
         timer_r <= timer_load_r;
         timer_run_r <= 1'b1;
         start_r <= 1'b1;
         tc_r <= 1'b0;
      end else begin
         tc_r <= 1'b0;
         if (timer_run_r) begin
            if (timer_r == 6'h00) begin
               timer_run_r <= 1'b0;
               start_r <= 1'b0;
               tc_r <= 1'b1;
            end else begin
               timer_r <= timer_r - 6'h01;
            end
         end
      end
   end
   assign interval_tc_out = tc_r;

   always_ff @(posedge ref_clk_in) begin
      if (rst_in || !(enabled & ctrl_r[sdt_pkg::CTRL_SENSE_EN_BIT])) begin
         delay_r <= delay_load_r;
         delay_run_r <= 1'b1;
      end else if (delay_run_r) begin
         if (delay_r == 6'h00) begin
            delay_run_r <= 1'b0;
         end else begin
            delay_r <= delay_r - 6'h01;
         end
      end
   end
   // ------------------------------------------------
   // counters, state and events
   // ------------------------------------------------
   assign count_en = ctrl_r[sdt_pkg::CTRL_POSINT_BIT] ? (enabled & ~frozen_r)
      : (sd_on & cmp_sync_r & start_r & ~frozen_r);
   assign lo_wrap = (cnt_lo_r == 8'hff);

   always_ff @(posedge ref_clk_in) begin
      if (rst_in || !enabled) begin
         cnt_lo_r <= 8'h00;
         cnt_hi_r <= 8'h00;
      end else if (count_en) begin
         cnt_lo_r <= cnt_lo_r + 8'h01;
         if (lo_wrap & ctrl_r[sdt_pkg::CTRL_CHAIN_BIT]) begin
            cnt_hi_r <= cnt_hi_r + 8'h01;
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in || !enabled) begin
         frozen_r <= 1'b0;
      end else if (trip & ctrl_r[sdt_pkg::CTRL_ONESHOT_BIT] & en_d_r) begin
         frozen_r <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in || !enabled) begin
         state_r <= sdt_pkg::SDT_IDLE;
      end else begin
         case (state_r)
            sdt_pkg::SDT_IDLE: state_r <= sdt_pkg::SDT_RUN;
            sdt_pkg::SDT_RUN: begin
               if (tc_r | frozen_r) begin
                  state_r <= sdt_pkg::SDT_DONE;
               end
            end
            sdt_pkg::SDT_DONE: state_r <= sdt_pkg::SDT_DONE;
            default: state_r <= sdt_pkg::SDT_IDLE;
         endcase
      end
   end

   // sticky; the set wins over the clear done by rewriting the control word
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         capture_ev_r <= 1'b0;
         ovf_ev_r <= 1'b0;
         delay_ev_r <= 1'b0;
      end else begin
         capture_ev_r <= (trip & en_d_r) | (capture_ev_r & ~wr_ctrl);
         ovf_ev_r <= (count_en & lo_wrap & (cnt_hi_r == 8'hff))
            | (ovf_ev_r & ~wr_ctrl);
         delay_ev_r <= (delay_run_r & (delay_r == 6'h00)
            & enabled & ctrl_r[sdt_pkg::CTRL_SENSE_EN_BIT]) | (delay_ev_r & ~wr_ctrl);
      end
   end
   assign block_event_out = ctrl_r[sdt_pkg::CTRL_INTSEL_BIT] ? ovf_ev_r
      : capture_ev_r;
   assign delay_event_out = delay_ev_r;
endmodule // sdt_touch_counter
`default_nettype wire

/* File: include/sdt_pkg.sv */
// package: register map, field positions, reset values and states of the touch counter
package sdt_pkg;
   // -------------------------------------------------
   // register word offsets (avalon word index)
   // -------------------------------------------------
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_SEQ = 4'h1;
   localparam logic [3:0] ADDR_TIMER = 4'h2;
   localparam logic [3:0] ADDR_DELAY = 4'h3;
   localparam logic [3:0] ADDR_CNT_LO = 4'h4;
   localparam logic [3:0] ADDR_CNT_HI = 4'h5;
   localparam logic [3:0] ADDR_STAT = 4'h6;
   localparam logic [3:0] ADDR_COUNT = 4'h7;
   // -------------------------------------------------
   // sense_control_0 fields
   // -------------------------------------------------
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_ONESHOT_BIT = 1;
   localparam int CTRL_INTSEL_BIT = 2;
   localparam int CTRL_SDMODE_BIT = 3;
   localparam int CTRL_SENSE_EN_BIT = 4;
   localparam int CTRL_PRSCLK_BIT = 5;
   localparam int CTRL_CHAIN_BIT = 6;
   localparam int CTRL_POSINT_BIT = 7;
   // -------------------------------------------------
   // sequencer register fields
   // -------------------------------------------------
   localparam int SEQ_DIV_LSB = 0;
   localparam int SEQ_DIV_MSB = 3;
   localparam int SEQ_LONG_BIT = 4;
   localparam logic [3:0] DIV_MAX = 4'h8;
   // -------------------------------------------------
   // reset values and seeds
   // -------------------------------------------------
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [4:0] SEQ_RST = 5'h00;
   localparam logic [5:0] TIMER_RST = 6'h3f;
   localparam logic [5:0] DELAY_RST = 6'h00;
   localparam logic [11:0] LFSR_SEED = 12'h001;
   localparam logic [7:0] DIV_RST = 8'h00;
   // -------------------------------------------------
   // measurement state
   // -------------------------------------------------
   typedef enum logic [1:0] {
      SDT_IDLE = 2'b00,
      SDT_RUN = 2'b01,
      SDT_DONE = 2'b11
   } sdt_state_t;
endpackage
